/* File: verilog/tpe_pkg.sv */
// package for the tracker parameter examine/change handler
// assumes one clock domain and byte-wide host command link
package tpe_pkg;

  localparam logic [7:0]  TPE_CMD_EXAMINE    = 8'h4F;
  localparam logic [7:0]  TPE_CMD_CHANGE     = 8'h50;
  localparam logic [7:0]  TPE_SEL_READY_CHAR = 8'h09;
  localparam logic [7:0]  TPE_SEL_ERROR      = 8'h0A;
  localparam logic [7:0]  TPE_SEL_NOISE      = 8'h0C;
  localparam logic [7:0]  TPE_SEL_UPPER      = 8'h0D;
  localparam logic [7:0]  TPE_SEL_LOCK       = 8'h0E;
  localparam logic [7:0]  TPE_SEL_MODEL      = 8'h0F;
  localparam logic [7:0]  TPE_SEL_FRAME      = 8'h11;

  localparam int          TPE_BANDS          = 7;
  localparam int          TPE_TABLE_BYTES    = 14;
  localparam int          TPE_MODEL_BYTES    = 10;
  localparam logic [4:0]  TPE_LEN_ONE        = 5'h01;
  localparam logic [4:0]  TPE_LEN_TABLE      = 5'h0E;
  localparam logic [4:0]  TPE_LEN_MODEL      = 5'h0A;

  localparam logic [7:0]  TPE_READY_CHAR_RST = 8'h2C;
  localparam logic [15:0] TPE_NOISE_NEAR_RST = 16'h0002;
  localparam logic [15:0] TPE_NOISE_FAR_RST  = 16'h0004;
  localparam logic [15:0] TPE_UPPER_RST      = 16'h7333;
  localparam logic [15:0] TPE_NOISE_MIN      = 16'h0001;
  localparam logic [15:0] TPE_NOISE_MAX      = 16'h7FFF;
  localparam logic [7:0]  TPE_NO_ERROR       = 8'h00;
  // identity string is arbitrary, padded with one space
  localparam logic [79:0] TPE_MODEL_STRING   = 80'h5450_4B2D_4D4F_4445_4C20;

  typedef enum logic [2:0] {
    TPE_IDLE   = 3'b000,
    TPE_SELECT = 3'b001,
    TPE_LOAD   = 3'b010,
    TPE_REPLY  = 3'b011,
    TPE_DROP   = 3'b100
  } tpe_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tpe_byte_t;

  typedef struct packed {
    logic [TPE_BANDS*16-1:0] noise;
    logic [TPE_BANDS*16-1:0] upper;
    logic                    lock;
    logic                    user_frame;
    logic [7:0]              ready_char;
  } tpe_config_t;

endpackage : tpe_pkg

/* File: verilog/tpe_table.sv */
// seven-word table, band 0 nearest, loaded byte by byte lsb first
// assumes the parser gives a byte index 0..13 with each write strobe
`timescale 1ns/1ns
module tpe_table
  import tpe_pkg::*;
#(
  parameter logic [15:0] NEAR_RST = 16'h0000,
  parameter logic [15:0] FAR_RST  = 16'h0000
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    wr_en,
  input  wire logic [4:0]              wr_index,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    commit,
  input  wire logic [4:0]              rd_index,
  output logic      [7:0]              rd_data,
  output logic      [TPE_BANDS*16-1:0] table_out
);

  logic [TPE_BANDS*16-1:0] table_reg;
  logic [TPE_BANDS*16-1:0] table_next;
  logic [TPE_BANDS*16-1:0] stage_reg;
  logic [TPE_BANDS*16-1:0] stage_next;

  // whole table swaps only after all bytes, so filter never sees half a table
  always_comb begin
    stage_next = stage_reg;
    table_next = table_reg;
    if (wr_en) begin
      stage_next[wr_index*8 +: 8] = wr_data; // RQ20
    end
    // the last byte lands with the commit, so swap in the updated stage
    if (commit) begin
      table_next = stage_next; // RQ19
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_reg <= {{(TPE_BANDS-1){FAR_RST}}, NEAR_RST};
      stage_reg <= '0;
    end else begin
      table_reg <= table_next;
      stage_reg <= stage_next;
    end
  end

  assign rd_data   = table_reg[rd_index*8 +: 8]; // RQ20
  assign table_out = table_reg;

endmodule : tpe_table

/* File: verilog/tpe_param.sv */
// Functional notes
// [RQ1] host sends change byte, selector, then payload bytes in order
// [RQ2] examine 9 returns current data-ready character byte
// [RQ3] change 9 takes one byte; ignored since unsupported
// [RQ4] examine 10 returns oldest held system error code
// [RQ5] parameter 12 noise table: 14 bytes read and written
// [RQ6] host keeps each noise entry within 1 to 32767
// [RQ7] noise table resets to 2 nearest band, 4 for others
// [RQ8] larger noise entry gives more filter lag for that band
// [RQ9] examine 13 returns seven upper coefficient limit words
// [RQ10] filter coefficient rises in fast motion, capped by band limit
// [RQ11] upper limits reset to 7333 hex in every band
// [RQ12] change 13 takes seven words; host keeps upper above lower
// [RQ13] examine 14 returns 1 when outputs frozen, else 0
// [RQ14] change 14 takes one byte: 0 unlocks, 1 locks
// [RQ15] examine 15 returns ten byte model string
// [RQ16] positions default to transmitter physical axes
// [RQ17] change 17: 1 follows user frame, 0 physical axes
// [RQ18] examine 17 returns 0 physical or 1 user frame
// [RQ19] written values persist until rewritten or reset
// [RQ20] tables move nearest band first as 16-bit words, lsb first
//
// parameter examine/change handler for selectors 9 to 17
// assumes byte stream in and out with valid/ready, synchronous to core_clk
`timescale 1ns/1ns
module tpe_param
  import tpe_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire tpe_byte_t               cmd_in,
  output logic                         cmd_ready,
  output tpe_byte_t                    reply_out,
  input  wire logic                    reply_ready,
  input  wire logic [7:0]              error_oldest,
  output logic                         error_pop,
  input  wire logic [TPE_BANDS*16-1:0] coeff_lower,
  input  wire logic [15:0]             coeff_raw,
  input  wire logic [2:0]              coeff_band,
  output logic      [15:0]             coeff_limited,
  output logic      [15:0]             band_noise,
  output tpe_config_t                  config_out,
  output logic                         bad_value
);

  tpe_state_t  state_reg,  state_next;
  logic        change_reg, change_next;
  logic [7:0]  sel_reg,    sel_next;
  logic [4:0]  count_reg,  count_next;
  logic [4:0]  len_reg,    len_next;
  logic        lock_reg,   lock_next;
  logic        frame_reg,  frame_next;
  logic        bad_reg,    bad_next;
  logic [7:0]  ready_char_reg, ready_char_next;
  tpe_byte_t   reply_reg,  reply_next;
  logic        pop_reg,    pop_next;
  logic [7:0]  stage_lo_reg, stage_lo_next;

  logic        noise_wr, upper_wr, noise_commit, upper_commit;
  logic [7:0]  noise_rd, upper_rd;
  logic [TPE_BANDS*16-1:0] noise_tab, upper_tab;
  logic        take;

  function automatic logic [4:0] reply_len(input logic [7:0] sel);
    case (sel)
      TPE_SEL_NOISE, TPE_SEL_UPPER: reply_len = TPE_LEN_TABLE;
      TPE_SEL_MODEL:                reply_len = TPE_LEN_MODEL;
      TPE_SEL_READY_CHAR, TPE_SEL_ERROR, TPE_SEL_LOCK,
      TPE_SEL_FRAME:                reply_len = TPE_LEN_ONE;
      default:                      reply_len = 5'h00;
    endcase
  endfunction : reply_len

  function automatic logic [15:0] band_word(input logic [TPE_BANDS*16-1:0] tab,
                                            input logic [2:0] band);
    band_word = tab[band*16 +: 16];
  endfunction : band_word

  // a closed table word must sit inside the host's noise range
  function automatic logic noise_in_range(input logic [15:0] word);
    noise_in_range = (word >= TPE_NOISE_MIN) && (word <= TPE_NOISE_MAX);
  endfunction : noise_in_range

  assign take      = cmd_in.valid && cmd_ready;
  assign cmd_ready = (state_reg != TPE_REPLY);

  always_comb begin
    state_next   = state_reg;
    change_next  = change_reg;
    sel_next     = sel_reg;
    count_next   = count_reg;
    len_next     = len_reg;
    lock_next    = lock_reg;
    frame_next   = frame_reg;
    bad_next     = bad_reg;
    reply_next   = reply_reg;
    pop_next     = 1'b0;
    noise_wr     = 1'b0;
    upper_wr     = 1'b0;
    noise_commit = 1'b0;
    upper_commit = 1'b0;
    if (reply_reg.valid && reply_ready) begin
      reply_next.valid = 1'b0;
    end
    case (state_reg)
      TPE_IDLE: begin
        if (take && cmd_in.data == TPE_CMD_CHANGE) begin // RQ1
          change_next = 1'b1;
          state_next  = TPE_SELECT;
        end else if (take && cmd_in.data == TPE_CMD_EXAMINE) begin
          change_next = 1'b0;
          state_next  = TPE_SELECT;
        end
      end
      TPE_SELECT: begin
        if (take) begin
          sel_next   = cmd_in.data;
          len_next   = reply_len(cmd_in.data);
          count_next = 5'h00;
          if (reply_len(cmd_in.data) == 5'h00) begin
            state_next = TPE_IDLE;
          end else if (change_reg) begin
            state_next = (cmd_in.data == TPE_SEL_ERROR ||
                          cmd_in.data == TPE_SEL_MODEL) ? TPE_IDLE : TPE_LOAD;
          end else begin
            state_next = TPE_REPLY;
          end
        end
      end
      TPE_LOAD: begin
        if (take) begin // RQ1
          count_next = count_reg + 5'h01;
          case (sel_reg)
            TPE_SEL_NOISE: begin
              noise_wr = 1'b1; // RQ5
              // odd byte closes a word: range check on the host's value
              if (count_reg[0] && !noise_in_range({cmd_in.data, stage_lo_reg})) begin
                bad_next = 1'b1; // RQ6
              end
            end
            TPE_SEL_UPPER: upper_wr = 1'b1; // RQ12
            TPE_SEL_LOCK:  lock_next  = (cmd_in.data != 8'h00); // RQ14
            TPE_SEL_FRAME: frame_next = (cmd_in.data != 8'h00); // RQ17
            default: ; // RQ3
          endcase
          if (count_reg + 5'h01 == len_reg) begin
            noise_commit = (sel_reg == TPE_SEL_NOISE);
            upper_commit = (sel_reg == TPE_SEL_UPPER);
            state_next   = TPE_IDLE;
          end
        end
      end
      TPE_REPLY: begin
        if (!reply_reg.valid || reply_ready) begin
          reply_next.valid = 1'b1;
          case (sel_reg)
            TPE_SEL_READY_CHAR: reply_next.data = ready_char_reg; // RQ2
            TPE_SEL_ERROR: begin
              reply_next.data = error_oldest; // RQ4
              pop_next        = 1'b1;
            end
            TPE_SEL_NOISE: reply_next.data = noise_rd; // RQ5
            TPE_SEL_UPPER: reply_next.data = upper_rd; // RQ9
            TPE_SEL_LOCK:  reply_next.data = {7'h00, lock_reg}; // RQ13
            TPE_SEL_MODEL: reply_next.data =
              TPE_MODEL_STRING[(TPE_MODEL_BYTES-1-count_reg)*8 +: 8]; // RQ15
            TPE_SEL_FRAME: reply_next.data = {7'h00, frame_reg}; // RQ18
            default:       reply_next.data = 8'h00;
          endcase
          count_next = count_reg + 5'h01;
          if (count_reg + 5'h01 == len_reg) begin
            state_next = TPE_IDLE;
          end
        end
      end
      default: state_next = TPE_IDLE;
    endcase
  end

  // low byte of the noise word being assembled, kept for the range check
  always_comb begin
    stage_lo_next = stage_lo_reg;
    if (noise_wr && !count_reg[0]) begin
      stage_lo_next = cmd_in.data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_lo_reg <= 8'h00;
    end else begin
      stage_lo_reg <= stage_lo_next;
    end
  end

  // marker change is not supported yet, so a change of 9 keeps the value
  always_comb begin
    ready_char_next = ready_char_reg; // RQ3
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_char_reg <= TPE_READY_CHAR_RST;
    end else begin
      ready_char_reg <= ready_char_next;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= TPE_IDLE;
      change_reg     <= 1'b0;
      sel_reg        <= 8'h00;
      count_reg      <= 5'h00;
      len_reg        <= 5'h00;
      lock_reg       <= 1'b0;
      frame_reg      <= 1'b0; // RQ16
      bad_reg        <= 1'b0;
      reply_reg      <= '0;
      pop_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      change_reg     <= change_next;
      sel_reg        <= sel_next;
      count_reg      <= count_next;
      len_reg        <= len_next;
      lock_reg       <= lock_next;
      frame_reg      <= frame_next;
      bad_reg        <= bad_next;
      reply_reg      <= reply_next;
      pop_reg        <= pop_next;
    end
  end

  tpe_table #(
    .NEAR_RST (TPE_NOISE_NEAR_RST),
    .FAR_RST  (TPE_NOISE_FAR_RST)
  ) u_noise ( // RQ7
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (noise_wr),
    .wr_index  (count_reg),
    .wr_data   (cmd_in.data),
    .commit    (noise_commit),
    .rd_index  (count_reg),
    .rd_data   (noise_rd),
    .table_out (noise_tab)
  );

  tpe_table #(
    .NEAR_RST (TPE_UPPER_RST),
    .FAR_RST  (TPE_UPPER_RST)
  ) u_upper ( // RQ11
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (upper_wr),
    .wr_index  (count_reg),
    .wr_data   (cmd_in.data),
    .commit    (upper_commit),
    .rd_index  (count_reg),
    .rd_data   (upper_rd),
    .table_out (upper_tab)
  );

  // cap on the adaptive coefficient; lower limit kept below by the host
  always_comb begin
    coeff_limited = coeff_raw;
    if (coeff_raw > band_word(upper_tab, coeff_band)) begin
      coeff_limited = band_word(upper_tab, coeff_band); // RQ10
    end
    if (coeff_limited < band_word(coeff_lower, coeff_band)) begin
      coeff_limited = band_word(coeff_lower, coeff_band); // RQ12
    end
  end

  // filter divides motion by this: bigger entry, smaller alpha, more lag
  assign band_noise            = band_word(noise_tab, coeff_band); // RQ8
  assign reply_out             = reply_reg;
  assign error_pop             = pop_reg;
  assign bad_value             = bad_reg;
  assign config_out.noise      = noise_tab;
  assign config_out.upper      = upper_tab;
  assign config_out.lock       = lock_reg; // RQ13
  assign config_out.user_frame = frame_reg; // RQ17
  assign config_out.ready_char = ready_char_reg; // RQ3

endmodule : tpe_param

/* File: tb/tpe_host.sv */
// host model: sends command bytes, takes reply bytes with optional stall
// assumes tasks are entered at a falling edge of core_clk
`timescale 1ns/1ns
module tpe_host
  import tpe_pkg::*;
(
  input  wire logic      core_clk,
  output tpe_byte_t      cmd_out,
  input  wire logic      cmd_ready,
  input  wire tpe_byte_t reply_in,
  output logic           reply_ready
);
  initial begin
    cmd_out = '0;
    reply_ready = 1'h0;
  end
  // valid stays up so bytes of one command go back to back
  task automatic send(input logic [7:0] b);
    cmd_out.valid = 1'h1;
    cmd_out.data = b;
    while (!cmd_ready) @(negedge core_clk);
    @(negedge core_clk);
  endtask : send
  // released line shows the inverse, never the old byte
  task automatic idle();
    cmd_out.valid = 1'h0;
    cmd_out.data = ~cmd_out.data;
  endtask : idle
  task automatic recv(input int stall, output logic [7:0] b);
    if (stall > 0) reply_ready = 1'h0;
    repeat (stall) @(negedge core_clk);
    while (!reply_in.valid) @(negedge core_clk);
    b = reply_in.data;
    reply_ready = 1'h1;
    @(negedge core_clk);
  endtask : recv
  task automatic rdone();
    reply_ready = 1'h0;
  endtask : rdone
endmodule : tpe_host

/* File: tb/tpe_param_chk.sv */
// checker for tpe_param, sees top ports only
// assumes bytes of one command arrive back to back
`timescale 1ns/1ns
module tpe_param_chk
  import tpe_pkg::*;
(
  input wire logic                    core_clk,
  input wire logic                    reset_n,
  input wire tpe_byte_t               cmd_in,
  input wire logic                    cmd_ready,
  input wire tpe_byte_t               reply_out,
  input wire logic                    reply_ready,
  input wire logic                    error_pop,
  input wire logic [TPE_BANDS*16-1:0] coeff_lower,
  input wire logic [15:0]             coeff_raw,
  input wire logic [2:0]              coeff_band,
  input wire logic [15:0]             coeff_limited,
  input wire logic [15:0]             band_noise,
  input wire tpe_config_t             config_out
);
  logic [15:0] up_w;
  logic [15:0] lo_w;
  assign up_w = config_out.upper[coeff_band*16 +: 16];
  assign lo_w = coeff_lower[coeff_band*16 +: 16];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take(logic [7:0] v);
    cmd_in.valid && cmd_ready && cmd_in.data == v;
  endsequence
  sequence s_change(logic [7:0] sel);
    s_take(TPE_CMD_CHANGE) ##1 s_take(sel) ##1 (cmd_in.valid && cmd_ready);
  endsequence
  a_reply_stands: assert property (reply_out.valid && !reply_ready |=>
    reply_out.valid && $stable(reply_out.data)) else $error("reply byte not held");
  a_busy_refuse: assert property (s_take(TPE_CMD_EXAMINE) ##1 s_take(TPE_SEL_NOISE) |=>
    !cmd_ready [*8]) else $error("command taken during reply");
  a_lock_write: assert property (s_change(TPE_SEL_LOCK) |=>
    config_out.lock == ($past(cmd_in.data) != 8'h00)) else $error("lock not written");
  a_frame_write: assert property (s_change(TPE_SEL_FRAME) |=>
    config_out.user_frame == ($past(cmd_in.data) != 8'h00)) else $error("frame not written");
  a_char_ignored: assert property (s_change(TPE_SEL_READY_CHAR) |=>
    $stable(config_out.ready_char)) else $error("ready char changed");
  a_lock_reply: assert property (s_take(TPE_CMD_EXAMINE) ##1 s_take(TPE_SEL_LOCK) |->
    ##2 reply_out.valid && reply_out.data == {7'h00, config_out.lock})
    else $error("lock reply wrong");
  a_frame_reply: assert property (s_take(TPE_CMD_EXAMINE) ##1 s_take(TPE_SEL_FRAME) |->
    ##2 reply_out.valid && reply_out.data == {7'h00, config_out.user_frame})
    else $error("frame reply wrong");
  a_pop_pulse: assert property (error_pop |=> !error_pop) else $error("pop too long");
  a_coeff_clamp: assert property (coeff_limited ==
    (coeff_raw > up_w ? up_w : (coeff_raw < lo_w ? lo_w : coeff_raw)))
    else $error("coefficient not clamped");
  a_noise_tap: assert property (band_noise == config_out.noise[coeff_band*16 +: 16])
    else $error("band noise wrong");
endmodule : tpe_param_chk

bind tpe_param tpe_param_chk u_chk (.core_clk, .reset_n, .cmd_in, .cmd_ready, .reply_out,
  .reply_ready, .error_pop, .coeff_lower, .coeff_raw, .coeff_band, .coeff_limited,
  .band_noise, .config_out);

/* File: tb/tb_tpe_param.sv */
// bench for tpe_param: host model on the byte link, checker bound
// assumes inputs change on the falling edge only
`timescale 1ns/1ns
module tb_tpe_param
  import tpe_pkg::*;
();
  logic                    core_clk = 1'h0;
  logic                    reset_n, cmd_ready, reply_ready, error_pop, bad_value;
  tpe_byte_t               cmd_in, reply_out;
  logic [7:0]              error_oldest;
  logic [TPE_BANDS*16-1:0] coeff_lower;
  logic [15:0]             coeff_raw, coeff_limited, band_noise;
  logic [2:0]              coeff_band;
  tpe_config_t             config_out;
  logic [111:0]            rx, nv, uv;
  int                      bad_count, comparisons, pops;

  always #4 core_clk = ~core_clk;
  // counted away from the edge that launches the pulse
  always @(negedge core_clk) if (error_pop === 1'h1) pops++;

  tpe_param uut (.core_clk, .reset_n, .cmd_in, .cmd_ready, .reply_out, .reply_ready,
    .error_oldest, .error_pop, .coeff_lower, .coeff_raw, .coeff_band, .coeff_limited,
    .band_noise, .config_out, .bad_value);
  tpe_host host (.core_clk, .cmd_out(cmd_in), .cmd_ready, .reply_in(reply_out), .reply_ready);

  task automatic chk(input string what, input logic [111:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // some bytes stalled so held replies get exercised
  task automatic examine(input logic [7:0] sel, input int n);
    logic [7:0] b;
    rx = '0;
    host.send(TPE_CMD_EXAMINE);
    host.send(sel);
    host.idle();
    for (int i = 0; i < n; i++) begin
      host.recv(i % 3 == 1 ? 2 : 0, b);
      rx[8*i +: 8] = b;
    end
    host.rdone();
  endtask : examine

  task automatic change(input logic [7:0] sel, input logic [111:0] v, input int n);
    host.send(TPE_CMD_CHANGE);
    host.send(sel);
    for (int i = 0; i < n; i++) host.send(v[8*i +: 8]);
    host.idle();
    repeat (2) @(negedge core_clk);
  endtask : change

  task automatic t_defaults();
    nv = {{6{TPE_NOISE_FAR_RST}}, TPE_NOISE_NEAR_RST};
    uv = {7{TPE_UPPER_RST}};
    chk("noise rst", nv, config_out.noise);
    chk("upper rst", uv, config_out.upper);
    chk("frame rst", 1'h0, config_out.user_frame);
    examine(TPE_SEL_NOISE, TPE_TABLE_BYTES);
    chk("noise rd", nv, rx);
    examine(TPE_SEL_UPPER, TPE_TABLE_BYTES);
    chk("upper rd", uv, rx);
    examine(TPE_SEL_READY_CHAR, 1);
    chk("char rd", TPE_READY_CHAR_RST, rx);
  endtask : t_defaults

  task automatic t_bytes();
    logic [111:0] ms = '0;
    for (int v = 1; v >= 0; v--) begin
      change(TPE_SEL_LOCK, 112'(v), 1);
      chk("lock cfg", 112'(v), config_out.lock);
      examine(TPE_SEL_LOCK, 1);
      chk("lock rd", 112'(v), rx);
      change(TPE_SEL_FRAME, 112'(v), 1);
      chk("frame cfg", 112'(v), config_out.user_frame);
      examine(TPE_SEL_FRAME, 1);
      chk("frame rd", 112'(v), rx);
    end
    change(TPE_SEL_READY_CHAR, 112'h41, 1);
    // unknown selector must drop back to idle with no reply
    host.send(TPE_CMD_EXAMINE);
    host.send(8'h10);
    host.idle();
    @(negedge core_clk);
    examine(TPE_SEL_READY_CHAR, 1);
    chk("char kept", TPE_READY_CHAR_RST, rx);
    pops = 0;
    examine(TPE_SEL_ERROR, 1);
    chk("error rd", error_oldest, rx);
    chk("error pop", 112'h1, pops);
    examine(TPE_SEL_MODEL, TPE_MODEL_BYTES);
    for (int i = 0; i < TPE_MODEL_BYTES; i++) ms[8*i +: 8] = TPE_MODEL_STRING[79-8*i -: 8];
    chk("model rd", ms, rx);
  endtask : t_bytes

  // entries at both ends of the legal noise range
  task automatic t_tables();
    nv = {16'h7FFF, 16'h0001, 16'h1234, 16'h0010, 16'h0200, 16'h3000, 16'h0003};
    uv = {16'h7FFF, 16'h6000, 16'h5000, 16'h4000, 16'h3000, 16'h2000, 16'h1000};
    change(TPE_SEL_NOISE, nv, TPE_TABLE_BYTES);
    change(TPE_SEL_UPPER, uv, TPE_TABLE_BYTES);
    chk("noise wr", nv, config_out.noise);
    chk("upper wr", uv, config_out.upper);
    examine(TPE_SEL_NOISE, TPE_TABLE_BYTES);
    chk("noise rd2", nv, rx);
    examine(TPE_SEL_UPPER, TPE_TABLE_BYTES);
    chk("upper rd2", uv, rx);
    for (int b = 0; b < TPE_BANDS; b++) begin
      coeff_band = 3'(b);
      coeff_raw = 16'h7FFF;
      @(negedge core_clk);
      chk("clamp hi", uv[16*b +: 16], coeff_limited);
      chk("noise tap", nv[16*b +: 16], band_noise);
      coeff_raw = 16'h0000;
      @(negedge core_clk);
      chk("clamp lo", coeff_lower[16*b +: 16], coeff_limited);
      coeff_raw = 16'h0200;
      @(negedge core_clk);
      chk("clamp mid", 16'h0200, coeff_limited);
    end
    chk("bad flag", 112'h0, bad_value);
  endtask : t_tables

  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    reset_n = 1'h0;
    error_oldest = 8'hA5;
    coeff_lower = {7{16'h0100}};
    coeff_raw = 16'h0000;
    coeff_band = 3'h0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'h1;
    @(negedge core_clk);
    t_defaults();
    t_bytes();
    t_tables();
    test_done();
  end

  // whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
endmodule : tb_tpe_param
